// ==== design/bldirq_bank.sv ====
// Boost/LDO interrupt enable, read-clear flags, soft-default key and thermistor select.
// Assumes a register port on the same clock (one-cycle rd/wr strobes) and
// asynchronous analog event levels, which are synchronised here.
`timescale 1ns/1ps
module bldirq_bank
   import bldirq_pkg::*;
(
   input  wire logic           clock,
   input  wire logic           rstn,
   input  wire bldirq_req_type req,
   input  wire bldirq_evt_type evt,
   input  wire logic           boost_standalone_fixed,
   input  wire logic           factory_thermistor_option,
   output logic [7:0]          rdata,
   output logic                irq_n,
   output logic                thermistor_47k_active
);

   logic [2:0] evt_vec;
   logic [2:0] evt_sync;
   logic [2:0] evt_prev;
   logic       mode_meta_r;
   logic       mode_sync_r;
   logic       opt_meta_r;
   logic       opt_sync_r;
   logic [2:0] irq_enable_r;
   logic [2:0] irq_flags_r;
   logic       thermistor_47k_select_r;
   logic [2:0] evt_rise;
   logic [2:0] flags_nxt;
   logic       restore;
   logic       flag_read;

   // Register address match, used by several processes
   function automatic logic hit(input bldirq_req_type r, input logic [7:0] a);
      return r.addr == a;
   endfunction

   // Monitor levels as one vector, LED open on bit 2, first LDO on bit 0
   assign evt_vec = evt;

   // Per source: two synchroniser stages, then an edge memory so a level
   // that stays high sets its flag once; only the second stage is read
   for (genvar s = 0; s < BLDIRQ_NUM_SRC; s++) begin : g_src
      logic meta_r;
      logic sync_r;
      logic prev_r;

      // First stage may go metastable, so nothing but sync_r reads it
      always_ff @(posedge clock) begin
         if (!rstn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
         end else begin
            meta_r <= evt_vec[s];
            sync_r <= meta_r;
         end
      end

      // Reset low matches the idle level of the monitors
      always_ff @(posedge clock) begin
         if (!rstn) begin
            prev_r <= 1'b0;
         end else begin
            prev_r <= sync_r;
         end
      end

      assign evt_sync[s] = sync_r;
      assign evt_prev[s] = prev_r;
   end

   // Boost operating mode, a slow level from the regulator control
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_meta_r <= 1'b0;
         mode_sync_r <= 1'b0;
      end else begin
         mode_meta_r <= boost_standalone_fixed;
         mode_sync_r <= mode_meta_r;
      end
   end

   // Factory option, fixed in use but still a foreign level
   always_ff @(posedge clock) begin
      if (!rstn) begin
         opt_meta_r <= 1'b0;
         opt_sync_r <= 1'b0;
      end else begin
         opt_meta_r <= factory_thermistor_option;
         opt_sync_r <= opt_meta_r;
      end
   end

   // Decoded strobes; the key write acts on the edge that takes it

   assign restore   = req.wr && hit(req, BLDIRQ_ADDR_RESTORE) &&
                      req.wdata == BLDIRQ_RESTORE_KEY;
   assign flag_read = req.rd && hit(req, BLDIRQ_ADDR_IRQ_FLAGS);

   // Rising edges; boost warning gated by its operating mode
   always_comb begin
      evt_rise = evt_sync & ~evt_prev;
      evt_rise[BLDIRQ_BIT_BOOST] = evt_rise[BLDIRQ_BIT_BOOST] & mode_sync_r;
   end

   // Flags: read clears, but a same-cycle event wins over the clear.
   // Losing that event would hide a fault the host never saw.
   // Flags set regardless of enable; the enable only gates the pin.
   always_comb begin
      flags_nxt = irq_flags_r;
      if (flag_read) begin
         flags_nxt = BLDIRQ_FLAGS_RESET;
      end
      flags_nxt = flags_nxt | evt_rise;
   end

   always_ff @(posedge clock) begin
      if (!rstn || restore) begin
         irq_flags_r <= BLDIRQ_FLAGS_RESET;
      end else begin
         irq_flags_r <= flags_nxt;
      end
   end

   // Enable register, writable bits [2:0] only
   // Upper bits are not stored and read back as zero
   always_ff @(posedge clock) begin
      if (!rstn || restore) begin
         irq_enable_r <= BLDIRQ_ENABLE_RESET;
      end else if (req.wr && hit(req, BLDIRQ_ADDR_IRQ_ENABLE)) begin
         irq_enable_r <= req.wdata[2:0];
      end
   end

   // Thermistor select, resets to the 47k choice
   always_ff @(posedge clock) begin
      if (!rstn || restore) begin
         thermistor_47k_select_r <= BLDIRQ_THERM_RESET;
      end else if (req.wr && hit(req, BLDIRQ_ADDR_THERM_SEL)) begin
         thermistor_47k_select_r <= req.wdata[BLDIRQ_BIT_THERM];
      end
   end

   // Effective choice only when the factory option allows it
   // With the option off the 100k part is assumed, so the output is low
   always_ff @(posedge clock) begin
      if (!rstn) begin
         thermistor_47k_active <= 1'b0;
      end else begin
         thermistor_47k_active <= opt_sync_r & thermistor_47k_select_r;
      end
   end

   // Interrupt pin, active low, registered from the next flag state.
   // Using the next state keeps the pin in step with the flag register,
   // so a read that clears the last enabled flag releases it at once.
   always_ff @(posedge clock) begin
      if (!rstn || restore) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= ~|(flags_nxt & irq_enable_r);
      end
   end

   // Read word for one address; unmapped and write-only addresses give zero
   function automatic logic [7:0] read_word(input logic [7:0] a,
                                            input logic [2:0] en,
                                            input logic [2:0] fl,
                                            input logic       sel);
      logic [7:0] w;
      w = 8'h00;
      case (a)
         BLDIRQ_ADDR_IRQ_ENABLE: w = {5'h00, en};
         BLDIRQ_ADDR_IRQ_FLAGS:  w = {5'h00, fl};
         BLDIRQ_ADDR_THERM_SEL:  w = {7'h00, sel};
         default:                w = 8'h00;           // write-only reads 0
      endcase
      return w;
   endfunction

   // Read data, registered one cycle after the read strobe; unused bits zero.
   // The flags are sampled before the clear, so the host sees what fired.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         rdata <= read_word(req.addr, irq_enable_r, irq_flags_r,
                            thermistor_47k_select_r);
      end
   end

endmodule

// ==== shared/bldirq_pkg.sv ====
// Package for the boost/LDO interrupt and defaults register bank.
// Assumes an 8-bit register port driven by the serial-link decoder.
package bldirq_pkg;
   // Register addresses on the 8-bit register port
   localparam logic [7:0] BLDIRQ_ADDR_IRQ_ENABLE = 8'h3a;
   localparam logic [7:0] BLDIRQ_ADDR_IRQ_FLAGS  = 8'h3b;
   localparam logic [7:0] BLDIRQ_ADDR_RESTORE    = 8'h3c;
   localparam logic [7:0] BLDIRQ_ADDR_THERM_SEL  = 8'h3d;
   // Reset values
   localparam logic [2:0] BLDIRQ_ENABLE_RESET    = 3'h0;
   localparam logic [2:0] BLDIRQ_FLAGS_RESET     = 3'h0;
   localparam logic       BLDIRQ_THERM_RESET     = 1'b1;
   // Key that restores every register
   localparam logic [7:0] BLDIRQ_RESTORE_KEY     = 8'h7f;
   // Bit positions shared by enable and flag registers, then the select register bit
   localparam int BLDIRQ_BIT_FIRST_LDO = 0;
   localparam int BLDIRQ_BIT_BOOST     = 1;
   localparam int BLDIRQ_BIT_LED_OPEN  = 2;
   localparam int BLDIRQ_BIT_THERM     = 0;
   localparam int BLDIRQ_NUM_SRC       = 3;

   // One register-port access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bldirq_req_type;

   // Raw event inputs from the analog monitors
   typedef struct packed {
      logic led_open;
      logic boost_pwr_good_warn;
      logic first_ldo_pwr_good_warn;
   } bldirq_evt_type;
endpackage

// ==== tb/bldirq_host.sv ====
// Host model driving the register port.
// Assumes the bank takes one-cycle strobes on the rising edge.
`timescale 1ns/1ps
module bldirq_host
   import bldirq_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [7:0] rdata,
   output bldirq_req_type  req
);
   initial req = '0;
   // One access; strobes dropped and address and data inverted after, so stale values never look valid
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clock);
      req <= '{w, !w, a, d};
      @(posedge clock);
      req <= '{1'b0, 1'b0, ~a, ~d};
      #1 q = rdata;
   endtask
endmodule

// ==== tb/bldirq_sva.sv ====
// Checker for the boost/LDO interrupt bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module bldirq_sva
   import bldirq_pkg::*;
(
   input wire logic           clock,
   input wire logic           rstn,
   input wire bldirq_req_type req,
   input wire bldirq_evt_type evt,
   input wire logic [7:0]     rdata,
   input wire logic           irq_n,
   input wire logic           thermistor_47k_active,
   input wire logic           factory_thermistor_option
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Decoded reads and the key write
   wire rd_en  = req.rd && req.addr == BLDIRQ_ADDR_IRQ_ENABLE;
   wire rd_fl  = req.rd && req.addr == BLDIRQ_ADDR_IRQ_FLAGS;
   wire key_wr = req.wr && req.addr == BLDIRQ_ADDR_RESTORE && req.wdata == BLDIRQ_RESTORE_KEY;
   AST_THERM: assert property (
      $rose(thermistor_47k_active) |-> $past(factory_thermistor_option, 2)) else $error("therm");
   AST_KEY: assert property (key_wr |=> irq_n) else $error("key");
   AST_EN_RD: assert property (rd_en |=> rdata[7:3] == 5'h00) else $error("en");
   AST_FL_RD: assert property (rd_fl |=> rdata[7:3] == 5'h00) else $error("fl");
   AST_SEL_RD: assert property (
      req.rd && req.addr == BLDIRQ_ADDR_THERM_SEL |=> rdata[7:1] == 7'h00) else $error("sel");
   AST_WO_RD: assert property (
      req.rd && req.addr == BLDIRQ_ADDR_RESTORE |=> rdata == 8'h00) else $error("wo");
   AST_HOLD: assert property (!req.rd |=> $stable(rdata)) else $error("hold");
   // Quiet monitors for four samples means no flag can be rising behind the read
   AST_CLEAR: assert property (rd_fl && evt == 3'h0 && $past(evt) == 3'h0 &&
      $past(evt, 2) == 3'h0 && $past(evt, 3) == 3'h0 |=> irq_n) else $error("clear");
   cover property ($fell(irq_n));
   cover property (key_wr);
   cover property (rd_fl ##1 rdata != 8'h00);
endmodule
bind bldirq_bank bldirq_sva u_sva (.clock(clock), .rstn(rstn), .req(req), .evt(evt),
   .rdata(rdata), .irq_n(irq_n), .thermistor_47k_active(thermistor_47k_active),
   .factory_thermistor_option(factory_thermistor_option));

// ==== tb/tb.sv ====
// Bench for the interrupt bank: event table, then ignored writes and restore.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb
   import bldirq_pkg::*;
;
   logic           clock = 1'b0, rstn = 1'b0, bsf = 1'b1, opt = 1'b1, irq_n, therm;
   logic [7:0]     rdata, q;
   bldirq_req_type req;
   bldirq_evt_type evt = '0;
   int             err_total = 0, samples_checked = 0;
   // Rows: event[6:4], enable[3:1], standalone mode[0]
   logic [6:0]     rows [7] = '{7'h49, 7'h41, 7'h25, 7'h24, 7'h13, 7'h1d, 7'h7f};
   bldirq_bank dut (.clock(clock), .rstn(rstn), .req(req), .evt(evt),
      .boost_standalone_fixed(bsf), .factory_thermistor_option(opt), .rdata(rdata),
      .irq_n(irq_n), .thermistor_47k_active(therm));
   bldirq_host host (.clock(clock), .rdata(rdata), .req(req));
   always #12.5 clock = ~clock;
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      logic [2:0] f;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      // Reset values, the unmapped 0x3e included
      for (int i = 0; i < 5; i++) begin
         host.acc(1'b0, 8'h3a + 8'(i), 8'h00, q);
         `CHK(q, (i == 3) ? 8'h01 : 8'h00)
      end
      `CHK({irq_n, therm}, 2'h3)
      foreach (rows[i]) begin
         f = rows[i][6:4] & {1'b1, rows[i][0], 1'b1};
         host.acc(1'b1, BLDIRQ_ADDR_IRQ_ENABLE, {5'h00, rows[i][3:1]}, q);
         bsf <= rows[i][0];
         @(posedge clock);
         evt <= rows[i][6:4];
         repeat (6) @(posedge clock);
         #1 `CHK(irq_n, ~|(f & rows[i][3:1]))
         host.acc(1'b0, BLDIRQ_ADDR_IRQ_FLAGS, 8'h00, q);
         `CHK(q, {5'h00, f})
         `CHK(irq_n, 1'b1)
         host.acc(1'b0, BLDIRQ_ADDR_IRQ_FLAGS, 8'h00, q);
         `CHK(q, 8'h00)
         evt <= '0;
      end
      // Wrong key and flag writes are ignored; select off, then key with pin low
      host.acc(1'b1, BLDIRQ_ADDR_IRQ_ENABLE, 8'hff, q);
      host.acc(1'b1, BLDIRQ_ADDR_RESTORE, 8'h55, q);
      host.acc(1'b1, BLDIRQ_ADDR_IRQ_FLAGS, 8'hff, q);
      host.acc(1'b1, BLDIRQ_ADDR_THERM_SEL, 8'h00, q);
      evt <= 3'h4;
      host.acc(1'b0, BLDIRQ_ADDR_IRQ_ENABLE, 8'h00, q);
      `CHK(q, 8'h07)
      repeat (4) @(posedge clock);
      #1 `CHK({irq_n, therm}, 2'h0)
      host.acc(1'b1, BLDIRQ_ADDR_RESTORE, BLDIRQ_RESTORE_KEY, q);
      `CHK(irq_n, 1'b1)
      host.acc(1'b0, BLDIRQ_ADDR_THERM_SEL, 8'h00, q);
      `CHK({q, therm}, 9'h003)
      opt <= 1'b0;
      repeat (3) @(posedge clock);
      #1 `CHK(therm, 1'b0)
      // Mid-run reset returns the enable to zero and the select to one
      host.acc(1'b1, BLDIRQ_ADDR_IRQ_ENABLE, 8'h05, q);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      host.acc(1'b0, BLDIRQ_ADDR_IRQ_ENABLE, 8'h00, q);
      `CHK(q, 8'h00)
      host.acc(1'b0, BLDIRQ_ADDR_THERM_SEL, 8'h00, q);
      `CHK({q, irq_n}, 9'h003)
      print_verdict();
   end
endmodule
